// file: core/mie_move_exec.sv
// execute stage for the move instruction family: accumulator, bank, page latch, pointers
`timescale 1ns/1ns
module mie_move_exec
   import mie_pkg::*;
(
   input  wire logic               clk_i,        // instruction clock
   input  wire logic               srst_i,       // synchronous reset, active high
   input  wire logic               op_valid_i,   // decoded instruction present
   input  wire mie_instr_t         instr_i,      // decoded instruction fields
   input  wire logic [ACC_W-1:0]   mem_rdata_i,  // read data, sampled in the same cycle as re
   input  wire logic               fp_wr_i,      // direct pointer write
   input  wire logic               fp_wr_sel_i,  // which pointer to write
   input  wire logic [PTR_W-1:0]   fp_wr_data_i, // value to write
   output logic                    busy_o,       // load in flight, no new op taken
   output logic      [ACC_W-1:0]   acc_o,        // accumulator
   output logic      [BANK_W-1:0]  bank_o,       // bank select
   output logic      [PCH_W-1:0]   pch_o,        // pc high latch
   output logic      [PTR_W-1:0]   fp0_o,        // file pointer 0
   output logic      [PTR_W-1:0]   fp1_o,        // file pointer 1
   output logic                    zero_o,       // zero flag
   output mie_mem_req_t            mem_req_o     // data memory request
);
   mie_state_t       state_reg;
   logic             busy_reg;
   logic [ACC_W-1:0] acc_reg;
   logic [BANK_W-1:0] bank_reg;
   logic [PCH_W-1:0] pch_reg;
   logic [PTR_W-1:0] fp_reg [2];
   logic             zero_reg;
   mie_mem_req_t     mem_req_reg;
   logic             take;
   logic             ind_op;
   logic [PTR_W-1:0] sel_fp;
   logic [PTR_W-1:0] ea;
   logic [PTR_W-1:0] ptr_new;
   logic [PTR_W-1:0] file_addr;

   // one op per cycle except while a load waits for its data
   assign take   = op_valid_i && (state_reg == ST_IDLE);
   assign ind_op = (instr_i.op == OP_IND_LOAD) || (instr_i.op == OP_IND_STORE);
   assign sel_fp = instr_i.ptr_sel ? fp_reg[1] : fp_reg[0];

   mie_ptr_unit u_ptr (
      .ptr_i     (sel_fp),
      .mode_i    (instr_i.mode),
      .rel_i     (instr_i.rel),
      .offset_i  (instr_i.offset),
      .ea_o      (ea),
      .ptr_new_o (ptr_new)
   );

   // window addresses hold nothing; they redirect to their pointer
   always_comb begin
      if (instr_i.faddr == WIN0_ADDR) begin
         file_addr = fp_reg[0];
      end else if (instr_i.faddr == WIN1_ADDR) begin
         file_addr = fp_reg[1];
      end else begin
         file_addr = {PAD_ZERO, bank_reg, instr_i.faddr};
      end
   end

   // sequencer: a load spends one extra cycle waiting for read data
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= ST_IDLE;
         busy_reg  <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (take && instr_i.op == OP_IND_LOAD) begin
                  state_reg <= ST_LOAD;
                  busy_reg  <= 1'b1;
               end
            end
            ST_LOAD: begin
               state_reg <= ST_IDLE;
               busy_reg  <= 1'b0;
            end
            default: begin
               state_reg <= ST_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end

   // memory request lasts exactly one cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mem_req_reg <= '0;
      end else begin
         mem_req_reg.we <= 1'b0;
         mem_req_reg.re <= 1'b0;
         if (take && ind_op) begin
            mem_req_reg.addr  <= ea;
            mem_req_reg.wdata <= acc_reg;
            mem_req_reg.re    <= (instr_i.op == OP_IND_LOAD);
            mem_req_reg.we    <= (instr_i.op == OP_IND_STORE);
         end else if (take && instr_i.op == OP_ACC_FILE) begin
            mem_req_reg.addr  <= file_addr;
            mem_req_reg.wdata <= acc_reg;
            mem_req_reg.we    <= 1'b1;
         end
      end
   end

   // pointers: an instruction update beats a direct write to the same pointer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fp_reg[0] <= PTR_RST;
         fp_reg[1] <= PTR_RST;
      end else begin
         if (fp_wr_i) begin
            fp_reg[fp_wr_sel_i] <= fp_wr_data_i;
         end
         if (take && ind_op) begin
            fp_reg[instr_i.ptr_sel] <= ptr_new;
         end
      end
   end

   // accumulator: literal load now, indirect load when data returns
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         acc_reg <= ACC_RST;
      end else if (state_reg == ST_LOAD) begin
         acc_reg <= mem_rdata_i;
      end else if (take && instr_i.op == OP_LIT_ACC) begin
         acc_reg <= instr_i.literal;
      end
   end

   // bank select and page latch
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bank_reg <= BANK_RST;
         pch_reg  <= PCH_RST;
      end else if (take) begin
         if (instr_i.op == OP_BANK_LIT) begin
            bank_reg <= instr_i.literal[BANK_W-1:0];
         end
         if (instr_i.op == OP_PAGE_LIT) begin
            pch_reg <= instr_i.literal[PCH_W-1:0];
         end
      end
   end

   // only a completed load touches the zero flag; pointer steps never do
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         zero_reg <= 1'b0;
      end else if (state_reg == ST_LOAD) begin
         zero_reg <= (mem_rdata_i == ACC_RST);
      end
   end

   assign busy_o    = busy_reg;
   assign acc_o     = acc_reg;
   assign bank_o    = bank_reg;
   assign pch_o     = pch_reg;
   assign fp0_o     = fp_reg[0];
   assign fp1_o     = fp_reg[1];
   assign zero_o    = zero_reg;
   assign mem_req_o = mem_req_reg;

   // checks on the visible behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   sequence load_issue_s;
      take && instr_i.op == OP_IND_LOAD;
   endsequence

   sequence load_done_s;
      ##1 (mem_req_o.re && busy_o) ##1 (!busy_o && acc_o == $past(mem_rdata_i));
   endsequence

   load_seq_a: assert property (load_issue_s |-> load_done_s)
      else $error("indirect load did not return data to the accumulator");

   load_zero_a: assert property (load_issue_s |-> ##2 (zero_o == (acc_o == ACC_RST)))
      else $error("zero flag wrong after indirect load");

   store_data_a: assert property (take && instr_i.op == OP_IND_STORE
      |=> mem_req_o.we && mem_req_o.wdata == $past(acc_o) && $stable(zero_o))
      else $error("indirect store wrote wrong data or touched a flag");

   store_once_a: assert property (mem_req_o.we |=> !mem_req_o.we || $past(take))
      else $error("write strobe held longer than one cycle");

   // expected address built from the mode encodings, not from the pointer unit
   mode_addr_a: assert property (take && ind_op && !instr_i.rel
      |=> mem_req_o.addr == (($past(instr_i.mode) == MODE_POST_INC
                              || $past(instr_i.mode) == MODE_POST_DEC) ? $past(sel_fp)
                             : ($past(instr_i.mode) == MODE_PRE_DEC) ? $past(sel_fp) - PTR_STEP
                             : $past(sel_fp) + PTR_STEP))
      else $error("pre or post mode used the wrong address");

   ptr_step_a: assert property (take && ind_op && !instr_i.rel && !instr_i.ptr_sel
      |=> fp0_o == ($past(instr_i.mode[MODE_DEC_BIT]) ? $past(fp0_o) - PTR_STEP
                    : $past(fp0_o) + PTR_STEP))
      else $error("pointer 0 not stepped by one");

   ptr_wrap_a: assert property (take && ind_op && !instr_i.rel && instr_i.ptr_sel
      && instr_i.mode == MODE_POST_INC && fp1_o == {PTR_W{1'b1}} |=> fp1_o == PTR_RST)
      else $error("pointer 1 did not wrap to zero");

   rel_keep_a: assert property (take && ind_op && instr_i.rel
      |=> mem_req_o.addr == $past(sel_fp) + mie_sext($past(instr_i.offset))
          && (($past(instr_i.ptr_sel) ? fp1_o : fp0_o) == $past(sel_fp)))
      else $error("relative form address or pointer wrong");

   flag_keep_a: assert property (take && instr_i.op != OP_IND_LOAD |=> $stable(zero_o))
      else $error("status flag changed by a non-load move");

   window_redirect_a: assert property (take && instr_i.op == OP_ACC_FILE
      && instr_i.faddr == WIN1_ADDR |=> mem_req_o.we && mem_req_o.addr == $past(fp1_o))
      else $error("window access not redirected through pointer");

   bank_lit_a: assert property (take && instr_i.op == OP_BANK_LIT
      |=> bank_o == $past(instr_i.literal[BANK_W-1:0]) && $stable(zero_o))
      else $error("bank select literal not loaded");

   page_lit_a: assert property (take && instr_i.op == OP_PAGE_LIT
      |=> pch_o == $past(instr_i.literal[PCH_W-1:0]) && $stable(zero_o))
      else $error("pc high latch literal not loaded");

   lit_acc_a: assert property (take && instr_i.op == OP_LIT_ACC
      |=> acc_o == $past(instr_i.literal) && !busy_o && $stable(zero_o))
      else $error("literal not in accumulator after one cycle");

   file_wr_a: assert property (take && instr_i.op == OP_ACC_FILE && instr_i.faddr > WIN1_ADDR
      |=> mem_req_o.we && mem_req_o.wdata == $past(acc_o)
          && mem_req_o.addr == {PAD_ZERO, $past(bank_o), $past(instr_i.faddr)})
      else $error("accumulator to file write wrong");
endmodule : mie_move_exec

// file: inc/mie_pkg.sv
// package for the move instruction execute block: widths, encodings, types and helpers
package mie_pkg;
   localparam int ACC_W   = 8;
   localparam int BANK_W  = 5;
   localparam int PCH_W   = 7;
   localparam int FADDR_W = 7;
   localparam int PTR_W   = 16;
   localparam int OFF_W   = 6;
   localparam int MODE_W  = 2;
   localparam int PAD_W   = PTR_W - BANK_W - FADDR_W;

   // update mode encodings and the two bits that carry their meaning
   localparam logic [MODE_W-1:0] MODE_PRE_INC  = 2'h0;
   localparam logic [MODE_W-1:0] MODE_PRE_DEC  = 2'h1;
   localparam logic [MODE_W-1:0] MODE_POST_INC = 2'h2;
   localparam logic [MODE_W-1:0] MODE_POST_DEC = 2'h3;
   localparam int MODE_DEC_BIT  = 0;
   localparam int MODE_POST_BIT = 1;

   // file addresses that stand for the two indirect windows
   localparam logic [FADDR_W-1:0] WIN0_ADDR = 7'h00;
   localparam logic [FADDR_W-1:0] WIN1_ADDR = 7'h01;

   // reset values, pointer step and file address pad
   localparam logic [ACC_W-1:0]  ACC_RST  = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
   localparam logic [PCH_W-1:0]  PCH_RST  = 7'h00;
   localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;
   localparam logic [PTR_W-1:0]  PTR_STEP = 16'h0001;
   localparam logic [PAD_W-1:0]  PAD_ZERO = 4'h0;

   typedef enum logic [2:0] {
      OP_IND_LOAD  = 3'h0,   // indirect_load_op
      OP_IND_STORE = 3'h1,   // indirect_store_op
      OP_BANK_LIT  = 3'h2,   // bank_literal_op
      OP_PAGE_LIT  = 3'h3,   // page_literal_op
      OP_LIT_ACC   = 3'h4,   // literal_to_acc_op
      OP_ACC_FILE  = 3'h5    // acc_to_file_op
   } mie_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_LOAD = 2'b10
   } mie_state_t;

   typedef struct packed {
      mie_op_t            op;
      logic               ptr_sel;
      logic [MODE_W-1:0]  mode;
      logic               rel;
      logic [OFF_W-1:0]   offset;
      logic [ACC_W-1:0]   literal;
      logic [FADDR_W-1:0] faddr;
   } mie_instr_t;

   typedef struct packed {
      logic [PTR_W-1:0] addr;
      logic [ACC_W-1:0] wdata;
      logic             we;
      logic             re;
   } mie_mem_req_t;

   // one step up or down, wrapping at both ends of the 16-bit range
   function automatic logic [PTR_W-1:0] mie_step(input logic [PTR_W-1:0] p, input logic dec);
      mie_step = dec ? (p - PTR_STEP) : (p + PTR_STEP);
   endfunction : mie_step

   // signed offset widened to pointer width
   function automatic logic [PTR_W-1:0] mie_sext(input logic [OFF_W-1:0] k);
      mie_sext = {{(PTR_W-OFF_W){k[OFF_W-1]}}, k};
   endfunction : mie_sext
endpackage : mie_pkg

// file: core/mie_ptr_unit.sv
// pointer arithmetic: effective address and updated pointer for one indirect move
`timescale 1ns/1ns
module mie_ptr_unit
   import mie_pkg::*;
(
   input  wire logic [PTR_W-1:0]  ptr_i,     // current pointer value
   input  wire logic [MODE_W-1:0] mode_i,    // update mode field
   input  wire logic              rel_i,     // relative offset form
   input  wire logic [OFF_W-1:0]  offset_i,  // signed offset
   output logic      [PTR_W-1:0]  ea_o,      // effective address
   output logic      [PTR_W-1:0]  ptr_new_o  // pointer after the move
);
   logic [PTR_W-1:0] adj;

   // plain 16-bit adder, so wraparound needs no special case
   assign adj = mie_step(ptr_i, mode_i[MODE_DEC_BIT]);

   // relative form leaves the pointer; pre modes address the adjusted value
   always_comb begin
      if (rel_i) begin
         ea_o      = ptr_i + mie_sext(offset_i);
         ptr_new_o = ptr_i;
      end else begin
         ea_o      = mode_i[MODE_POST_BIT] ? ptr_i : adj;
         ptr_new_o = adj;
      end
   end
endmodule : mie_ptr_unit

// file: tb/mie_move_exec_tb_top.sv
// self-checking testbench for the move instruction execute block
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module mie_move_exec_tb_top;
   import mie_pkg::*;
   logic               clk_i;
   logic               srst_i;
   logic               op_valid_i;
   mie_instr_t         instr_i;
   logic [ACC_W-1:0]   mem_rdata_i;
   logic               fp_wr_i;
   logic               fp_wr_sel_i;
   logic [PTR_W-1:0]   fp_wr_data_i;
   logic               busy_o;
   logic [ACC_W-1:0]   acc_o;
   logic [BANK_W-1:0]  bank_o;
   logic [PCH_W-1:0]   pch_o;
   logic [PTR_W-1:0]   fp0_o;
   logic [PTR_W-1:0]   fp1_o;
   logic               zero_o;
   mie_mem_req_t       mem_req_o;
   int                 n_mismatch = 0;
   int                 cmp_count = 0;

   mie_move_exec dut (.clk_i(clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
      .instr_i(instr_i), .mem_rdata_i(mem_rdata_i), .fp_wr_i(fp_wr_i),
      .fp_wr_sel_i(fp_wr_sel_i), .fp_wr_data_i(fp_wr_data_i), .busy_o(busy_o),
      .acc_o(acc_o), .bank_o(bank_o), .pch_o(pch_o), .fp0_o(fp0_o), .fp1_o(fp1_o),
      .zero_o(zero_o), .mem_req_o(mem_req_o));

   // 100 mhz instruction clock
   initial clk_i = 1'b0;
   always #5 clk_i = ~clk_i;

   // build one decoded instruction
   function automatic mie_instr_t mk(input mie_op_t op, input logic s, input logic [1:0] m,
                                     input logic r, input logic [5:0] k,
                                     input logic [7:0] l, input logic [6:0] f);
      mk = '{op: op, ptr_sel: s, mode: m, rel: r, offset: k, literal: l, faddr: f};
   endfunction : mk

   // present one op; returns at the negedge after the take with valid still up,
   // so back-to-back ops never reassign valid in one step; the caller lowers it
   task automatic run(input mie_instr_t ins);
      op_valid_i = 1'b1;
      instr_i    = ins;
      @(negedge clk_i);
   endtask : run

   // direct pointer load, used only to set up pointer start values
   task automatic set_fp(input logic s, input logic [PTR_W-1:0] v);
      fp_wr_i      = 1'b1;
      fp_wr_sel_i  = s;
      fp_wr_data_i = v;
      @(negedge clk_i);
      fp_wr_i      = 1'b0;
   endtask : set_fp

   task automatic conclude();
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // every output cleared by reset
   task automatic t_reset();
      `CHK({acc_o, bank_o, pch_o, fp0_o, fp1_o, zero_o, busy_o}, 54'h0)
      `CHK(mem_req_o, 26'h0)
   endtask : t_reset

   // indirect load: one-cycle read, busy refuses a new op, zero follows the byte
   task automatic t_load(input logic s, input logic [1:0] m, input logic [PTR_W-1:0] p,
                         input logic [PTR_W-1:0] ea, input logic [PTR_W-1:0] np,
                         input logic [7:0] d, input logic refuse);
      set_fp(s, p);
      run(mk(OP_IND_LOAD, s, m, 1'b0, 6'h00, 8'h00, 7'h00));
      `CHK({mem_req_o.re, mem_req_o.we, busy_o}, 3'b101)
      `CHK(mem_req_o.addr, ea)
      `CHK(s ? fp1_o : fp0_o, np)
      mem_rdata_i = d;
      // an op offered while busy must be dropped, not queued
      op_valid_i  = refuse;
      instr_i     = mk(OP_LIT_ACC, 1'b0, 2'h0, 1'b0, 6'h00, 8'haa, 7'h00);
      @(negedge clk_i);
      op_valid_i  = 1'b0;
      mem_rdata_i = ~d;
      `CHK(acc_o, d)
      `CHK(zero_o, (d == 8'h00))
      `CHK({busy_o, mem_req_o.re}, 2'b00)
      @(negedge clk_i);
      `CHK(acc_o, d)
   endtask : t_load

   // literal ops at their range ends, flags left alone, unused codes inert
   task automatic t_literals();
      run(mk(OP_BANK_LIT, 1'b0, 2'h0, 1'b0, 6'h00, 8'h1f, 7'h00));
      `CHK(bank_o, 5'h1f)
      run(mk(OP_PAGE_LIT, 1'b0, 2'h0, 1'b0, 6'h00, 8'h7f, 7'h00));
      `CHK(pch_o, 7'h7f)
      `CHK(bank_o, 5'h1f)
      run(mk(OP_LIT_ACC, 1'b0, 2'h0, 1'b0, 6'h00, 8'hff, 7'h00));
      `CHK(acc_o, 8'hff)
      // zero literal must not raise the zero flag
      run(mk(OP_LIT_ACC, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00, 7'h00));
      `CHK({acc_o, zero_o}, 9'h000)
      run(mk(mie_op_t'(3'h6), 1'b0, 2'h0, 1'b0, 6'h00, 8'h55, 7'h55));
      run(mk(mie_op_t'(3'h7), 1'b0, 2'h0, 1'b0, 6'h00, 8'h55, 7'h55));
      `CHK({acc_o, bank_o, pch_o, mem_req_o.we}, {8'h00, 5'h1f, 7'h7f, 1'b0})
      run(mk(OP_BANK_LIT, 1'b0, 2'h0, 1'b0, 6'h00, 8'h15, 7'h00));
      `CHK(bank_o, 5'h15)
      op_valid_i = 1'b0;
   endtask : t_literals

   // all four update modes on both pointers, each starting at a wrap boundary
   task automatic t_store_modes();
      logic [1:0]       m;
      logic             s;
      logic [PTR_W-1:0] p;
      logic [PTR_W-1:0] np;
      logic [PTR_W-1:0] ea;
      for (int i = 0; i < 8; i++) begin
         m  = i[1:0];
         s  = i[2];
         p  = m[0] ? 16'h0000 : 16'hffff;
         np = m[0] ? 16'hffff : 16'h0000;
         ea = m[1] ? p : np;
         set_fp(s, p);
         run(mk(OP_LIT_ACC, 1'b0, 2'h0, 1'b0, 6'h00, 8'h30 + 8'(i), 7'h00));
         run(mk(OP_IND_STORE, s, m, 1'b0, 6'h00, 8'h00, 7'h00));
         `CHK(mem_req_o.addr, ea)
         `CHK({mem_req_o.we, mem_req_o.re, mem_req_o.wdata}, {2'b10, 8'h30 + 8'(i)})
         `CHK(s ? fp1_o : fp0_o, np)
         `CHK(zero_o, 1'b1)
         op_valid_i = 1'b0;
      end
      @(negedge clk_i);
      `CHK(mem_req_o.we, 1'b0)
   endtask : t_store_modes

   // relative form at both offset limits, pointer left unchanged
   task automatic t_relative();
      set_fp(1'b0, 16'h1000);
      run(mk(OP_IND_STORE, 1'b0, 2'h2, 1'b1, 6'h20, 8'h00, 7'h00));
      `CHK({mem_req_o.we, mem_req_o.addr, fp0_o}, {1'b1, 16'h0fe0, 16'h1000})
      op_valid_i = 1'b0;
      set_fp(1'b1, 16'hfff0);
      run(mk(OP_IND_LOAD, 1'b1, 2'h0, 1'b1, 6'h1f, 8'h00, 7'h00));
      `CHK({mem_req_o.re, mem_req_o.addr, fp1_o}, {1'b1, 16'h000f, 16'hfff0})
      mem_rdata_i = 8'h81;
      op_valid_i  = 1'b0;
      @(negedge clk_i);
      `CHK({acc_o, zero_o}, 9'h102)
   endtask : t_relative

   // accumulator to file: plain banked address and both indirect windows
   task automatic t_acc_file();
      set_fp(1'b0, 16'h2345);
      // one idle edge so the strobe is not raised again in the step it fell
      @(negedge clk_i);
      set_fp(1'b1, 16'hbeef);
      run(mk(OP_ACC_FILE, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00, 7'h7f));
      `CHK({mem_req_o.we, mem_req_o.addr, mem_req_o.wdata}, {1'b1, 4'h0, 5'h15, 7'h7f, 8'h81})
      run(mk(OP_ACC_FILE, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00, WIN0_ADDR));
      `CHK({mem_req_o.we, mem_req_o.addr}, {1'b1, 16'h2345})
      run(mk(OP_ACC_FILE, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00, WIN1_ADDR));
      `CHK({mem_req_o.we, mem_req_o.addr, zero_o}, {1'b1, 16'hbeef, 1'b0})
   endtask : t_acc_file

   // main sequence; inputs change only at the falling edge
   initial begin
      srst_i       = 1'b1;
      op_valid_i   = 1'b0;
      instr_i      = '0;
      mem_rdata_i  = 8'hff;
      fp_wr_i      = 1'b0;
      fp_wr_sel_i  = 1'b0;
      fp_wr_data_i = 16'h0000;
      repeat (5) @(negedge clk_i);
      srst_i = 1'b0;
      t_reset();
      t_load(1'b0, MODE_POST_INC, 16'h0040, 16'h0040, 16'h0041, 8'h5a, 1'b1);
      t_literals();
      t_load(1'b1, MODE_PRE_DEC, 16'h0000, 16'hffff, 16'hffff, 8'h00, 1'b0);
      t_store_modes();
      t_relative();
      t_acc_file();
      conclude();
   end

   // watchdog: the whole sequence needs well under 200 cycles
   initial begin
      #20000;
      n_mismatch++;
      conclude();
   end
endmodule : mie_move_exec_tb_top
